/* core/flash_ctl_regs.svh */
// Register offsets, field positions and reset values of the flash control
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

`define OFS_MAIN_KEY 8'h04
`define OFS_OPT_KEY 8'h08
`define OFS_STATUS 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_ADDR 8'h14
`define OFS_PROG_DATA 8'h28

`define ST_BUSY 0
`define ST_PROG_FAULT 2
`define ST_WP_FAULT 4
`define ST_DONE 5
`define ST_PATTERN 8
`define ST_CONFIG 9

`define CT_PROG 0
`define CT_PAGE 1
`define CT_MASS 2
`define CT_OPT_PROG 4
`define CT_OPT_ERASE 5
`define CT_START 6
`define CT_LOCK 7
`define CT_PARTIAL 8
`define CT_OPT_ALLOW 9
`define CT_FAULT_EN 10
`define CT_DONE_EN 12

`define CTRL_RW_MASK 32'h0000_1537
`define RESET_CONTROL 32'h0000_0080
`define RESET_ADDR 32'h0000_0000
`define RESET_WORD 32'h0000_0000
`define ERASED_WORD 32'hFFFF_FFFF
`define SINGLE_PAGE 8'h01
`define PARTIAL_ERASE_PAGES 8'h30

`endif

/* core/flash_ctl_pkg.sv */
// Types shared by the flash program and erase control
package flash_ctl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_CHECK = 3'h2,
      ST_RUN = 3'h4
   } seq_state_t;

   typedef enum logic [2:0] {
      OP_PROGRAM = 3'h0,
      OP_PAGE_ERASE = 3'h1,
      OP_MASS_ERASE = 3'h2,
      OP_PARTIAL_ERASE = 3'h3,
      OP_OPT_PROGRAM = 3'h4,
      OP_OPT_ERASE = 3'h5
   } op_t;

endpackage

/* core/key_if.sv */
// Key word path between the control block and a key sequence matcher
`timescale 1ns/1ps
interface key_if;
   logic wr;
   logic [31:0] word;
   logic rearm;
   logic match;
   logic fail;

   modport source(output wr, output word, output rearm,
                  input match, input fail);
   modport sink(input wr, input word, input rearm,
                output match, output fail);
endinterface

/* core/sticky_flag.sv */
// Status flag set by hardware and cleared by software, set winning
`timescale 1ns/1ps
module sticky_flag (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic set_in,
   input wire logic clear_in,
   output logic flag_out
);
   logic flag_reg;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= set_in | (flag_reg & ~clear_in);
      end
   end

   assign flag_out = flag_reg;
endmodule

/* core/key_matcher.sv */
// Two-word unlock key sequence matcher
`timescale 1ns/1ps
module key_matcher #(
   parameter logic [31:0] FIRST = 32'h0000_0000,
   parameter logic [31:0] SECOND = 32'h0000_0000
) (
   input wire logic clk_in,
   input wire logic reset_in,
   key_if.sink key
);
   logic second_reg;
   logic match_reg;
   logic fail_reg;

   wire want_first = key.wr & ~fail_reg & ~second_reg;
   wire want_second = key.wr & ~fail_reg & second_reg;
   wire first_ok = want_first & (key.word == FIRST);
   wire second_ok = want_second & (key.word == SECOND);
   wire bad_word = (want_first | want_second) & ~first_ok & ~second_ok;

   // A wrong word latches the failure until rearmed or reset
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         second_reg <= 1'b0;
         match_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         second_reg <= first_ok | (second_reg & ~key.wr & ~key.rearm);
         match_reg <= second_ok;
         fail_reg <= bad_word | (fail_reg & ~key.rearm);
      end
   end

   assign key.match = match_reg;
   assign key.fail = fail_reg;
endmodule

/* core/flash_program_erase_control.sv */
// Flash program and erase control with its APB register file
// Functional notes
// [RULE_01] Write-only option key register; correct sequence sets option write allow.
// [RULE_02] Option bytes may be programmed or erased only while allow is set.
// [RULE_03] Config flag set when start-up config value differs from calibration.
// [RULE_04] Pattern flag set when start-up pattern differs from calibration.
// [RULE_05] Done flag set on each successful operation; write 1 clears.
// [RULE_06] Programming a protected address sets write-protect fault; 1 clears.
// [RULE_07] Programming a word that is not all ones sets program fault.
// [RULE_08] Software keeps erase start at 0 before programming.
// [RULE_09] Busy rises when an operation begins, falls at end or error.
// [RULE_10] Done interrupt raised when done flag and its enable are set.
// [RULE_11] Fault interrupt raised when either fault flag and its enable set.
// [RULE_12] Partial erase select clears only the first 48 main pages.
// [RULE_13] Lock resets to 1, only writes of 1; locks array and control.
// [RULE_14] Correct main key clears lock; a failed attempt freezes it.
// [RULE_15] Start is set by software only, cleared as busy rises.
// [RULE_16] Option erase select enables option erase mode.
// [RULE_17] Option program select enables option program mode.
// [RULE_18] Mass erase select makes an erase clear every main page.
// [RULE_19] Control bit 0 selects program, bit 1 single page erase.
// [RULE_20] Address register gives program word or erase page.
// [RULE_21] Address writes are ignored while busy.
// [RULE_22] Separate write-only main key register clears the lock.
// [RULE_23] Key words are parameters, compared in written order.
// [RULE_24] Interrupt is OR of enabled done and enabled faults.
`timescale 1ns/1ps
`include "flash_ctl_regs.svh"
module flash_program_erase_control #(
   parameter logic [31:0] MAIN_KEY_FIRST = 32'h1111_2222,
   parameter logic [31:0] MAIN_KEY_SECOND = 32'h3333_4444,
   parameter logic [31:0] OPT_KEY_FIRST = 32'h5555_6666,
   parameter logic [31:0] OPT_KEY_SECOND = 32'h7777_8888,
   parameter logic [7:0] MAIN_PAGES = 8'h40,
   parameter int CFG_W = 32
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic array_req_out,
   output logic [2:0] array_cmd_out,
   output logic [31:0] array_addr_out,
   output logic [31:0] array_wdata_out,
   output logic [7:0] array_pages_out,
   input wire logic [31:0] array_rdata_in,
   input wire logic array_protect_in,
   input wire logic array_done_in,
   input wire logic [CFG_W-1:0] config_value_in,
   input wire logic [CFG_W-1:0] config_calib_in,
   input wire logic [CFG_W-1:0] pattern_value_in,
   input wire logic [CFG_W-1:0] pattern_calib_in,
   output logic irq_out
);
   flash_ctl_pkg::seq_state_t state_reg;
   flash_ctl_pkg::seq_state_t state_next;
   flash_ctl_pkg::op_t cmd_reg;
   flash_ctl_pkg::op_t op_pick;
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] status_word;
   logic [31:0] prdata_reg;
   logic [7:0] pages_reg;
   logic [7:0] pages_pick;
   logic pready_reg;
   logic pslverr_reg;
   logic req_reg;
   logic irq_reg;
   logic cfg_seen_reg;
   logic cfg_err_reg;
   logic pat_err_reg;
   logic done_flag;
   logic wp_flag;
   logic pg_flag;
   logic done_set;
   logic wp_set;
   logic pg_set;

   key_if main_key ();
   key_if opt_key ();

   // Bus decode
   wire setup = psel_in & ~penable_in;
   wire access = psel_in & penable_in & pready_reg;
   wire wr_en = access & pwrite_in;
   wire hit_main = paddr_in == `OFS_MAIN_KEY;
   wire hit_opt = paddr_in == `OFS_OPT_KEY;
   wire hit_status = paddr_in == `OFS_STATUS;
   wire hit_ctrl = paddr_in == `OFS_CONTROL;
   wire hit_addr = paddr_in == `OFS_ADDR;
   wire hit_data = paddr_in == `OFS_PROG_DATA;
   wire hit_any = hit_main | hit_opt | hit_status | hit_ctrl
                  | hit_addr | hit_data;

   // Control fields
   wire lock = ctrl_reg[`CT_LOCK];
   wire start = ctrl_reg[`CT_START];
   wire opt_allow = ctrl_reg[`CT_OPT_ALLOW];
   wire sel_prog = ctrl_reg[`CT_PROG];
   wire sel_page = ctrl_reg[`CT_PAGE];
   wire sel_mass = ctrl_reg[`CT_MASS];
   wire sel_partial = ctrl_reg[`CT_PARTIAL];
   wire sel_opt_prog = ctrl_reg[`CT_OPT_PROG];
   wire sel_opt_erase = ctrl_reg[`CT_OPT_ERASE];
   wire done_en = ctrl_reg[`CT_DONE_EN];
   wire fault_en = ctrl_reg[`CT_FAULT_EN];

   wire idle = state_reg == flash_ctl_pkg::ST_IDLE;
   wire busy = ~idle;

   // Register writes
   wire ctrl_wr = wr_en & hit_ctrl & ~lock; // [RULE_13]
   wire addr_wr = wr_en & hit_addr & idle; // [RULE_21]
   wire status_wr = wr_en & hit_status;
   wire data_wr = wr_en & hit_data & idle & ~lock;

   // Operation launch; a pending start blocks programming
   wire prog_mode = sel_prog | sel_opt_prog; // [RULE_19] [RULE_17]
   wire erase_mode = sel_page | sel_mass | sel_partial | sel_opt_erase;
   wire prog_go = data_wr & prog_mode & ~start; // [RULE_08]
   wire erase_go = idle & start & ~lock & erase_mode; // [RULE_15]
   wire start_clr = idle & start;

   // Option erase ranks first, then mass, partial, single page
   assign op_pick = prog_go ? (sel_opt_prog
                    ? flash_ctl_pkg::OP_OPT_PROGRAM // [RULE_17]
                    : flash_ctl_pkg::OP_PROGRAM)    // [RULE_19]
                  : sel_opt_erase ? flash_ctl_pkg::OP_OPT_ERASE // [RULE_16]
                  : sel_mass ? flash_ctl_pkg::OP_MASS_ERASE // [RULE_18]
                  : sel_partial ? flash_ctl_pkg::OP_PARTIAL_ERASE // [RULE_12]
                  : flash_ctl_pkg::OP_PAGE_ERASE; // [RULE_19]

   assign pages_pick = (op_pick == flash_ctl_pkg::OP_PARTIAL_ERASE)
                       ? `PARTIAL_ERASE_PAGES // [RULE_12]
                       : (op_pick == flash_ctl_pkg::OP_MASS_ERASE)
                       ? MAIN_PAGES // [RULE_18]
                       : `SINGLE_PAGE;

   // Checks made before the array is driven
   wire is_opt = cmd_reg == flash_ctl_pkg::OP_OPT_PROGRAM
                 | cmd_reg == flash_ctl_pkg::OP_OPT_ERASE;
   wire is_prog = cmd_reg == flash_ctl_pkg::OP_PROGRAM
                  | cmd_reg == flash_ctl_pkg::OP_OPT_PROGRAM;
   wire is_main_target = cmd_reg == flash_ctl_pkg::OP_PROGRAM
                         | cmd_reg == flash_ctl_pkg::OP_PAGE_ERASE;
   wire opt_denied = is_opt & ~opt_allow; // [RULE_02]
   wire wp_hit = opt_denied
                 | (is_main_target & array_protect_in); // [RULE_06]
   wire not_blank = is_prog & (array_rdata_in != `ERASED_WORD); // [RULE_07]

   always_comb begin
      state_next = state_reg;
      wp_set = 1'b0;
      pg_set = 1'b0;
      done_set = 1'b0;
      unique case (state_reg)
         flash_ctl_pkg::ST_IDLE: begin
            if (prog_go | erase_go) begin
               state_next = flash_ctl_pkg::ST_CHECK; // [RULE_09]
            end
         end
         flash_ctl_pkg::ST_CHECK: begin
            // A failed check ends the operation with busy falling
            if (wp_hit) begin
               wp_set = 1'b1; // [RULE_06]
               state_next = flash_ctl_pkg::ST_IDLE; // [RULE_09]
            end else if (not_blank) begin
               pg_set = 1'b1; // [RULE_07]
               state_next = flash_ctl_pkg::ST_IDLE; // [RULE_09]
            end else begin
               state_next = flash_ctl_pkg::ST_RUN;
            end
         end
         flash_ctl_pkg::ST_RUN: begin
            if (array_done_in) begin
               done_set = 1'b1; // [RULE_05]
               state_next = flash_ctl_pkg::ST_IDLE; // [RULE_09]
            end
         end
         default: begin
            state_next = flash_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   // Control register next value
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = pwdata_in & `CTRL_RW_MASK;
         // Start and lock only accept ones
         ctrl_next[`CT_START] = start | (pwdata_in[`CT_START] & idle);
         ctrl_next[`CT_LOCK] = pwdata_in[`CT_LOCK]; // [RULE_13]
         // Software may only clear option write allow
         ctrl_next[`CT_OPT_ALLOW] = opt_allow
                                   & pwdata_in[`CT_OPT_ALLOW]; // [RULE_02]
      end
      if (start_clr) begin
         ctrl_next[`CT_START] = 1'b0; // [RULE_15]
      end
      if (main_key.match) begin
         ctrl_next[`CT_LOCK] = 1'b0; // [RULE_14]
      end
      if (opt_key.match) begin
         ctrl_next[`CT_OPT_ALLOW] = 1'b1; // [RULE_01]
      end
   end

   // Key paths: main key only while locked, option key only when open
   assign main_key.wr = wr_en & hit_main & lock; // [RULE_22]
   assign main_key.word = pwdata_in;
   assign main_key.rearm = 1'b0; // [RULE_14]
   assign opt_key.wr = wr_en & hit_opt & ~lock; // [RULE_01]
   assign opt_key.word = pwdata_in;
   assign opt_key.rearm = opt_key.fail;

   key_matcher #(
      .FIRST(MAIN_KEY_FIRST),
      .SECOND(MAIN_KEY_SECOND)
   ) main_matcher ( // [RULE_23]
      .clk_in(clk_in),
      .reset_in(reset_in),
      .key(main_key)
   );

   key_matcher #(
      .FIRST(OPT_KEY_FIRST),
      .SECOND(OPT_KEY_SECOND)
   ) opt_matcher ( // [RULE_23]
      .clk_in(clk_in),
      .reset_in(reset_in),
      .key(opt_key)
   );

   sticky_flag done_stat ( // [RULE_05]
      .clk_in(clk_in),
      .reset_in(reset_in),
      .set_in(done_set),
      .clear_in(status_wr & pwdata_in[`ST_DONE]),
      .flag_out(done_flag)
   );

   sticky_flag wp_stat ( // [RULE_06]
      .clk_in(clk_in),
      .reset_in(reset_in),
      .set_in(wp_set),
      .clear_in(status_wr & pwdata_in[`ST_WP_FAULT]),
      .flag_out(wp_flag)
   );

   sticky_flag pg_stat ( // [RULE_07]
      .clk_in(clk_in),
      .reset_in(reset_in),
      .set_in(pg_set),
      .clear_in(status_wr & pwdata_in[`ST_PROG_FAULT]),
      .flag_out(pg_flag)
   );

   always_comb begin
      status_word = `RESET_WORD;
      status_word[`ST_BUSY] = busy; // [RULE_09]
      status_word[`ST_PROG_FAULT] = pg_flag;
      status_word[`ST_WP_FAULT] = wp_flag;
      status_word[`ST_DONE] = done_flag;
      status_word[`ST_PATTERN] = pat_err_reg;
      status_word[`ST_CONFIG] = cfg_err_reg;
   end

   // Key registers are write-only and read as zero
   wire [31:0] rdata_mux = hit_status ? status_word
                         : hit_ctrl ? ctrl_reg
                         : hit_addr ? addr_reg
                         : hit_data ? wdata_reg
                         : `RESET_WORD;

   wire irq_next = (done_flag & done_en) // [RULE_10] [RULE_24]
                   | ((pg_flag | wp_flag) & fault_en); // [RULE_11]

   // One wait-free access cycle; read data captured in setup
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= `RESET_WORD;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~hit_any;
         prdata_reg <= setup ? rdata_mux : `RESET_WORD;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= flash_ctl_pkg::ST_IDLE;
         ctrl_reg <= `RESET_CONTROL; // [RULE_13]
         irq_reg <= 1'b0;
         req_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         irq_reg <= irq_next;
         req_reg <= state_next == flash_ctl_pkg::ST_RUN;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         addr_reg <= `RESET_ADDR;
         wdata_reg <= `RESET_WORD;
      end else begin
         if (addr_wr) begin
            addr_reg <= pwdata_in; // [RULE_20]
         end
         if (data_wr) begin
            wdata_reg <= pwdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cmd_reg <= flash_ctl_pkg::OP_PROGRAM;
         pages_reg <= `SINGLE_PAGE;
      end else if (idle & (prog_go | erase_go)) begin
         cmd_reg <= op_pick;
         pages_reg <= pages_pick;
      end
   end

   // Comparison is taken once, on the first edge after reset release
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cfg_seen_reg <= 1'b0;
         cfg_err_reg <= 1'b0;
         pat_err_reg <= 1'b0;
      end else if (!cfg_seen_reg) begin
         cfg_seen_reg <= 1'b1;
         cfg_err_reg <= config_value_in != config_calib_in; // [RULE_03]
         pat_err_reg <= pattern_value_in != pattern_calib_in; // [RULE_04]
      end
   end

   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;
   assign array_req_out = req_reg;
   assign array_cmd_out = cmd_reg;
   assign array_addr_out = addr_reg; // [RULE_20]
   assign array_wdata_out = wdata_reg;
   assign array_pages_out = pages_reg;
   assign irq_out = irq_reg;
endmodule

/* tb/flash_program_erase_control_chk.sv */
// Port-level assertions for the flash program and erase control
`timescale 1ns/1ps
module flash_program_erase_control_chk #(
   parameter logic [7:0] MAIN_PAGES = 8'h40
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic array_req_out,
   input wire logic [2:0] array_cmd_out,
   input wire logic [31:0] array_addr_out,
   input wire logic [7:0] array_pages_out,
   input wire logic array_done_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire logic setup = psel_in && !penable_in;
   wire logic mapped = paddr_in inside {8'h04, 8'h08, 8'h0C, 8'h10,
      8'h14, 8'h28};
   wire logic key_rd = !pwrite_in && paddr_in inside {8'h04, 8'h08};

   ready_after_setup_a: assert property (setup |=> pready_out)
      else $error("no ready in the access cycle");
   ready_one_cycle_a: assert property (pready_out |=> !pready_out)
      else $error("ready held longer than one cycle");
   unmapped_error_a: assert property (setup && !mapped |=>
      pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
   mapped_no_error_a: assert property (setup && mapped |=> !pslverr_out)
      else $error("mapped access refused");
   key_reads_zero_a: assert property (setup && key_rd |=>
      prdata_out == 32'h0)
      else $error("key register read not zero");
   request_holds_a: assert property (array_req_out && !array_done_in |=>
      array_req_out && $stable(array_cmd_out) && $stable(array_addr_out))
      else $error("array request changed before done");
   done_ends_req_a: assert property (array_req_out && array_done_in |=>
      !array_req_out)
      else $error("array request outlived done");
   partial_pages_a: assert property (array_req_out &&
      array_cmd_out == flash_ctl_pkg::OP_PARTIAL_ERASE |->
      array_pages_out == 8'h30)
      else $error("partial erase page count wrong");
   mass_pages_a: assert property (array_req_out &&
      array_cmd_out == flash_ctl_pkg::OP_MASS_ERASE |->
      array_pages_out == MAIN_PAGES)
      else $error("mass erase page count wrong");
   single_page_a: assert property (array_req_out &&
      array_cmd_out inside {3'h0, 3'h1} |-> array_pages_out == 8'h01)
      else $error("single page count wrong");

   cover property (array_req_out && array_cmd_out == 3'h2);
   cover property (array_req_out && array_cmd_out == 3'h5);
   cover property (pslverr_out);
endmodule

bind flash_program_erase_control flash_program_erase_control_chk #(
   .MAIN_PAGES(MAIN_PAGES)) flash_program_erase_control_chk_i (.clk_in,
   .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
   .pready_out, .pslverr_out, .array_req_out, .array_cmd_out,
   .array_addr_out, .array_pages_out, .array_done_in);

/* tb/tb.sv */
// Self-checking bench for the flash program and erase control
`timescale 1ns/1ps
module tb;
   // Key words are arbitrary
   localparam logic [31:0] MK1 = 32'hA1B2_C3D4;
   localparam logic [31:0] MK2 = 32'h0F1E_2D3C;
   localparam logic [31:0] OK1 = 32'h4B5A_6978;
   localparam logic [31:0] OK2 = 32'h8796_A5B4;
   localparam logic [7:0] PAGES = 8'h40;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, array_rdata_in = 32'hFFFF_FFFF;
   logic array_protect_in = 1'b0, array_done_in = 1'b0;
   logic [7:0] cfg_v = 8'h5A, cfg_c = 8'hA5, pat_v = 8'h3C, pat_c = 8'h3C;
   logic [31:0] prdata_out, array_addr_out, array_wdata_out, rd;
   logic pready_out, pslverr_out, array_req_out, irq_out, err, ok;
   logic [2:0] array_cmd_out;
   logic [7:0] array_pages_out;
   int n_errors = 0;
   int n_compared = 0;

   flash_program_erase_control #(.MAIN_KEY_FIRST(MK1), .MAIN_KEY_SECOND(MK2),
      .OPT_KEY_FIRST(OK1), .OPT_KEY_SECOND(OK2), .MAIN_PAGES(PAGES),
      .CFG_W(8)) flash_program_erase_control_i (.clk_in, .reset_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .array_req_out, .array_cmd_out,
      .array_addr_out, .array_wdata_out, .array_pages_out, .array_rdata_in,
      .array_protect_in, .array_done_in, .config_value_in(cfg_v),
      .config_calib_in(cfg_c), .pattern_value_in(pat_v),
      .pattern_calib_in(pat_c), .irq_out);

   initial begin
      forever #25 clk_in = ~clk_in;
   end

   task automatic stop_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Ready is sampled in the low phase so the edge that ends the
   // access never races the slave's own update
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(negedge clk_in);
         ok = pready_out;
         rd = prdata_out;
         err = pslverr_out;
         @(posedge clk_in);
         n++;
      end while (ok !== 1'b1 && n < 20);
      check({31'h0, ok}, 32'h1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   task automatic rst();
      @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
   endtask

   // Waits for launch, tries an address write while busy, then finishes
   task automatic run(input logic [2:0] cmd, input logic [7:0] pg,
                      input logic [31:0] wd);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (array_req_out !== 1'b1 && n < 20);
      check({29'h0, array_cmd_out}, {29'h0, cmd});
      if (cmd < 3'h4) check({24'h0, array_pages_out}, {24'h0, pg});
      if (cmd == 3'h0) check(array_wdata_out, wd);
      wr(8'h14, 32'hFFFF_FFFF);
      @(negedge clk_in);
      check(array_addr_out, 32'h100);
      @(posedge clk_in);
      array_done_in <= 1'b1;
      @(posedge clk_in);
      array_done_in <= 1'b0;
      rdchk(8'h0C, 32'h220);
      rdchk(8'h14, 32'h100);
   endtask

   task automatic t_startup();
      rdchk(8'h10, 32'h80);
      rdchk(8'h0C, 32'h200);
      rdchk(8'h04, 32'h0);
      rdchk(8'h40, 32'h0);
      check({31'h0, err}, 32'h1);
   endtask

   task automatic t_unlock();
      wr(8'h10, 32'h1);
      rdchk(8'h10, 32'h80);
      wr(8'h04, MK1);
      wr(8'h04, MK2);
      repeat (3) @(posedge clk_in);
      rdchk(8'h10, 32'h0);
      wr(8'h08, OK1);
      wr(8'h08, OK2);
      repeat (3) @(posedge clk_in);
      rdchk(8'h10, 32'h200);
      wr(8'h10, 32'h0);
      rdchk(8'h10, 32'h0);
   endtask

   task automatic t_program();
      wr(8'h10, 32'h1001);
      wr(8'h14, 32'h100);
      wr(8'h28, 32'hA5A5_0F0F);
      run(3'h0, 8'h01, 32'hA5A5_0F0F);
      check({31'h0, irq_out}, 32'h1);
      wr(8'h0C, 32'h20);
      rdchk(8'h0C, 32'h200);
      check({31'h0, irq_out}, 32'h0);
   endtask

   task automatic t_faults();
      for (int i = 0; i < 2; i++) begin
         wr(8'h10, 32'h0401);
         array_rdata_in <= (i == 0) ? 32'h0 : 32'hFFFF_FFFF;
         array_protect_in <= (i == 1);
         wr(8'h28, 32'h1234_5678);
         repeat (4) @(posedge clk_in);
         rdchk(8'h0C, (i == 0) ? 32'h204 : 32'h210);
         check({31'h0, irq_out}, 32'h1);
         wr(8'h0C, 32'h14);
         rdchk(8'h0C, 32'h200);
      end
      array_rdata_in <= 32'hFFFF_FFFF;
      array_protect_in <= 1'b0;
      check({31'h0, irq_out}, 32'h0);
   endtask

   task automatic t_erase();
      logic [31:0] sel [4] = '{32'h2, 32'h4, 32'h100, 32'h220};
      logic [2:0] cmd [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
      logic [7:0] pg [4] = '{8'h01, PAGES, 8'h30, 8'h00};
      for (int i = 0; i < 4; i++) begin
         if (i == 3) begin
            wr(8'h08, OK1);
            wr(8'h08, OK2);
         end
         wr(8'h10, sel[i]);
         wr(8'h10, sel[i] | 32'h40);
         run(cmd[i], pg[i], 32'h0);
         rdchk(8'h10, sel[i]);
         wr(8'h0C, 32'h20);
      end
      wr(8'h10, 32'h210);
      wr(8'h28, 32'h0000_00FF);
      run(3'h4, 8'h00, 32'h0);
      wr(8'h0C, 32'h20);
      wr(8'h10, 32'h0);
      wr(8'h10, 32'h10);
      wr(8'h28, 32'h0000_00FF);
      repeat (4) @(posedge clk_in);
      rdchk(8'h0C, 32'h210);
      wr(8'h0C, 32'h10);
   endtask

   task automatic t_badkey();
      rst();
      wr(8'h04, MK2);
      wr(8'h04, MK1);
      wr(8'h04, MK2);
      repeat (3) @(posedge clk_in);
      rdchk(8'h10, 32'h80);
      rdchk(8'h0C, 32'h200);
   endtask

   initial begin
      #2000000;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   initial begin
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      t_startup();
      t_unlock();
      t_program();
      t_faults();
      t_erase();
      t_badkey();
      stop_test();
   end
endmodule
